// >>> rtl/cam_cfg_map.svh
/*
  Offsets, codes and timing counts for the camera configuration controller.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef CAM_CFG_MAP_SVH
`define CAM_CFG_MAP_SVH
`define HS_IDLE 2'h0
`define HS_READ 2'h1
`define HS_WRITE 2'h2
`define REG_SEL_HANDSHAKE 2'h0
`define REG_SEL_INDEX 2'h1
`define REG_SEL_VALUE 2'h2
`define ADDR_WRITE 8'hBA
`define ADDR_READ 8'hBB
`define CLK_RATE_HZ 20000000
`define SCL_RATE_HZ 100000
`define QUARTER_CYCLES ((`CLK_RATE_HZ + 4 * `SCL_RATE_HZ - 1) / (4 * `SCL_RATE_HZ))
`define BUSY_LIMIT_CYCLES (200 * `QUARTER_CYCLES)
`define PIXEL_WIDTH 10
`endif

// >>> rtl/cam_cfg_pkg.sv
/*
  Types for the camera configuration controller.
  Assumes cam_cfg_map.svh is on the include path.
*/
`default_nettype none
`include "cam_cfg_map.svh"
package cam_cfg_pkg;
  typedef struct packed {
    logic [`PIXEL_WIDTH-1:0] value;
    logic line_valid;
    logic frame_valid;
  } pixel_type;
endpackage
`default_nettype wire

// >>> rtl/pixel_skid_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides for pixel words.
  Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module pixel_skid_buffer
  import cam_cfg_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire pixel_type in_data,
  input wire logic in_valid,
  output logic in_ready,
  output pixel_type out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    pixel_type [1:0] entry;
    logic [1:0] occupied;
  } buf_state_type;
  buf_state_type state;
  buf_state_type next_state;
  logic push;
  logic pop;

  initial begin
    if (DEPTH != 2) $error("pixel_skid_buffer serves only two entries");
  end

  // Entry 0 is the head so the output word comes straight from a flop.
  // Occupied is a thermometer: bit 0 holds one word, bit 1 holds two.
  always_comb begin
    push = in_valid && !state.occupied[1];
    pop = state.occupied[0] && out_ready;
    next_state = state;
    if (pop) begin
      next_state.entry[0] = state.entry[1];
    end
    if (push && state.occupied[0] && !pop) begin
      next_state.entry[1] = in_data;
    end else if (push) begin
      next_state.entry[0] = in_data;
    end
    if (push && !pop) begin
      next_state.occupied = {state.occupied[0], 1'b1};
    end else if (pop && !push) begin
      next_state.occupied = {1'b0, state.occupied[1]};
    end
  end

  // Registers the state.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign in_ready = ~state.occupied[1];
  assign out_valid = state.occupied[0];
  assign out_data = state.entry[0];
endmodule
`default_nettype wire

// >>> rtl/camera_serial_config_controller.sv
/*
  Camera configuration controller: three software registers on a simple
  register port, a two-wire serial master for sensor registers, and a
  registered pixel path that buffers up to two pixels and flags overrun.
  Assumes a 20 MHz REF_CLK, synchronous RESET, pull-ups on both serial lines
  and a pixel clock well below half of REF_CLK.
*/
//Contract
//- Software registers drive serial transfers only
//- Hardware clears handshake when transfer finishes
//- Writing 1 starts read, reads 1
//- Writing 2 starts write; 3+ invalid
//- Read value held, valid after clear
//- Data register is 16 bits
//- No frame storage, one pixel period
//- Start, address 0xBA, then acknowledge
//- Index byte then acknowledge
//- High byte, low byte, each acknowledged
//- Stop: clock high, then data high
`default_nettype none
`include "cam_cfg_map.svh"
module camera_serial_config_controller
  import cam_cfg_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [1:0] REG_SELECT,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [15:0] REG_WRITE_DATA,
  output logic [15:0] REG_READ_DATA,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_CLOCK_OE,
  input wire logic SERIAL_DATA_LINE_IN,
  output logic SERIAL_DATA_LINE_OUT,
  output logic SERIAL_DATA_LINE_OE,
  output logic ACK_ERROR,
  input wire logic PIXEL_CLOCK,
  input wire logic [`PIXEL_WIDTH-1:0] PIXEL_DATA,
  input wire logic LINE_VALID,
  input wire logic FRAME_VALID,
  output logic [`PIXEL_WIDTH-1:0] PIXEL_OUT,
  output logic PIXEL_OUT_VALID,
  output logic PIXEL_OUT_LINE,
  output logic PIXEL_OUT_FRAME,
  input wire logic PIXEL_OUT_READY,
  output logic PIXEL_OVERRUN
);
  localparam int QUARTER = `QUARTER_CYCLES;
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER - 1);
  localparam int BUSY_LIMIT = `BUSY_LIMIT_CYCLES;

  typedef enum logic [5:0] {
    IDLE = 6'b000001,
    START = 6'b000010,
    SHIFT = 6'b000100,
    RESTART = 6'b001000,
    STOP = 6'b010000,
    DONE = 6'b100000
  } phase_type;

  typedef struct packed {
    logic [1:0] handshake;
    logic [7:0] index;
    logic [15:0] value;
    logic [15:0] read_data;
    phase_type phase;
    logic [7:0] tick;
    logic [1:0] quarter;
    logic [3:0] bit_count;
    logic [2:0] byte_count;
    logic [8:0] shift;
    logic scl;
    logic sda;
    logic ack_error;
    logic [1:0] sda_sync;
    logic [2:0] pclk_sync;
    pixel_type pix_in;
    logic pix_valid;
    logic overrun;
    logic [15:0] busy_cycles;
    logic scl_oe;
    logic sda_oe;
    pixel_type pin_stage1;
    pixel_type pin_stage2;
  } ctrl_state_type;

  ctrl_state_type state;
  ctrl_state_type next_state;
  logic tick_end;
  logic last_byte;
  logic is_read;
  logic sample_bit;
  logic pix_ready;
  pixel_type pix_out;
  logic pix_out_valid;

  // Rate limit for the serial clock: four quarter phases per bit period.
  initial begin
    if (QUARTER < 1 || QUARTER > 256) $error("serial clock divider out of range");
  end

  // Two-entry buffer keeps a stalled receiver from losing up to two pixels.
  pixel_skid_buffer #(
    .DEPTH(2)
  ) pixel_buffer (
    .clk(REF_CLK),
    .reset(RESET),
    .in_data(state.pix_in),
    .in_valid(state.pix_valid),
    .in_ready(pix_ready),
    .out_data(pix_out),
    .out_valid(pix_out_valid),
    .out_ready(PIXEL_OUT_READY)
  );

  // Next-state logic for registers, serial master and pixel capture.
  always_comb begin
    next_state = state;
    tick_end = (state.tick == QUARTER_LAST);
    is_read = (state.handshake == `HS_READ);
    // Write: addr, index, high, low. Read: addr, index, read addr, high, low.
    last_byte = is_read ? (state.byte_count == 3'h4) : (state.byte_count == 3'h3);
    sample_bit = state.sda_sync[1];
    next_state.sda_sync = {state.sda_sync[0], SERIAL_DATA_LINE_IN};
    next_state.pclk_sync = {state.pclk_sync[1:0], PIXEL_CLOCK};
    next_state.pin_stage1 = {PIXEL_DATA, LINE_VALID, FRAME_VALID}; // Two-stage pin sync.
    next_state.pin_stage2 = state.pin_stage1;
    next_state.tick = tick_end ? 8'h00 : 8'(state.tick + 8'h01);
    if (tick_end) begin
      next_state.quarter = 2'(state.quarter + 2'h1);
    end
    // Software access; commands are taken only while idle.
    if (REG_WRITE) begin
      unique case (REG_SELECT)
        `REG_SEL_HANDSHAKE: begin
          if (state.phase == IDLE && (REG_WRITE_DATA[1:0] == `HS_READ ||
              REG_WRITE_DATA[1:0] == `HS_WRITE) && REG_WRITE_DATA[15:2] == '0) begin
            next_state.handshake = REG_WRITE_DATA[1:0];
            next_state.ack_error = 1'b0;
          end
        end
        `REG_SEL_INDEX: next_state.index = REG_WRITE_DATA[7:0];
        `REG_SEL_VALUE: next_state.value = REG_WRITE_DATA;
        default: next_state.index = state.index;
      endcase
    end
    if (REG_READ) begin
      unique case (REG_SELECT)
        `REG_SEL_HANDSHAKE: next_state.read_data = {14'h0000, state.handshake};
        `REG_SEL_INDEX: next_state.read_data = {8'h00, state.index};
        `REG_SEL_VALUE: next_state.read_data = state.value;
        default: next_state.read_data = 16'h0000;
      endcase
    end
    // Serial master sequencing on quarter-period ticks.
    unique case (state.phase)
      IDLE: begin
        next_state.scl = 1'b1;
        next_state.sda = 1'b1;
        next_state.tick = 8'h00;
        next_state.quarter = 2'h0;
        if (state.handshake != `HS_IDLE) begin
          next_state.phase = START;
          next_state.byte_count = 3'h0;
        end
      end
      START, RESTART: if (tick_end) begin
        unique case (state.quarter)
          2'h0: next_state.sda = 1'b1;
          2'h1: next_state.scl = 1'b1;
          2'h2: next_state.sda = 1'b0;
          2'h3: begin
            next_state.scl = 1'b0;
            next_state.phase = SHIFT;
            next_state.bit_count = 4'h0;
            next_state.shift = (state.phase == RESTART) ? {`ADDR_READ, 1'b1} :
              {`ADDR_WRITE, 1'b1};
          end
        endcase
      end
      SHIFT: if (tick_end) begin
        unique case (state.quarter)
          2'h0: next_state.sda = state.shift[8];
          2'h1: next_state.scl = 1'b1;
          2'h2: begin
            if (state.bit_count == 4'h8) begin
              if (is_read && state.byte_count >= 3'h3) begin
                next_state.shift = state.shift;
              end else if (sample_bit) begin
                next_state.ack_error = 1'b1;
              end
            end else if (is_read && state.byte_count >= 3'h3) begin // Received bits only.
              next_state.shift = {state.shift[7:0], sample_bit};
            end
          end
          2'h3: begin
            next_state.scl = 1'b0;
            if (state.bit_count == 4'h7 && is_read && state.byte_count >= 3'h3) begin
              // Received byte: acknowledge high byte, release for the last.
              if (state.byte_count == 3'h3) begin
                next_state.value[15:8] = state.shift[7:0];
              end else begin
                next_state.value[7:0] = state.shift[7:0];
              end
              next_state.shift = {last_byte, 8'h00};
              next_state.bit_count = 4'h8;
            end else if (state.bit_count == 4'h7) begin
              next_state.shift = 9'h1FF; // Release data for the acknowledge bit.
              next_state.bit_count = 4'h8;
            end else if (state.bit_count == 4'h8) begin
              next_state.byte_count = 3'(state.byte_count + 3'h1);
              next_state.bit_count = 4'h0;
              if (last_byte) begin
                next_state.phase = STOP;
              end else if (is_read && state.byte_count == 3'h1) begin
                next_state.phase = RESTART;
              end else if (state.byte_count == 3'h0) begin
                next_state.shift = {state.index, 1'b1};
              end else if (!is_read && state.byte_count == 3'h1) begin
                next_state.shift = {state.value[15:8], 1'b1};
              end else if (!is_read) begin
                next_state.shift = {state.value[7:0], 1'b1};
              end else begin
                next_state.shift = 9'h1FF; // Release data to receive.
              end
            end else begin
              next_state.bit_count = 4'(state.bit_count + 4'h1);
              if (!(is_read && state.byte_count >= 3'h3)) begin
                next_state.shift = {state.shift[7:0], 1'b1};
              end
            end
          end
        endcase
      end
      STOP: if (tick_end) begin
        unique case (state.quarter)
          2'h0: next_state.sda = 1'b0;
          2'h1: next_state.scl = 1'b1;
          2'h2: next_state.sda = 1'b1;
          2'h3: next_state.phase = DONE;
        endcase
      end
      DONE: begin
        next_state.handshake = `HS_IDLE;
        next_state.phase = IDLE;
      end
    endcase
    // Pixels are taken on the synchronised rising pixel clock edge.
    next_state.pix_valid = 1'b0;
    if (state.pclk_sync[1] && !state.pclk_sync[2]) begin
      next_state.pix_in = state.pin_stage2;
      next_state.pix_valid = 1'b1;
    end
    if (state.pix_valid && !pix_ready) begin
      next_state.overrun = 1'b1;
    end
    if (state.handshake == `HS_IDLE) begin // Busy time, held at the top if stuck.
      next_state.busy_cycles = 16'h0000;
    end else if (state.busy_cycles != 16'hFFFF) begin
      next_state.busy_cycles = 16'(state.busy_cycles + 16'h0001);
    end
    // Line enables are registered so the pins come straight from flops.
    next_state.scl_oe = ~next_state.scl;
    next_state.sda_oe = ~next_state.sda;
  end

  // Registers the state; RESET restores idle with handshake zero.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state <= '0;
      state.phase <= IDLE;
      state.scl <= 1'b1;
      state.sda <= 1'b1;
      state.sda_sync <= 2'h3;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come from flops; open-drain lines drive only low.
  assign REG_READ_DATA = state.read_data;
  assign SERIAL_CLOCK_OUT = 1'b0;
  assign SERIAL_CLOCK_OE = state.scl_oe;
  assign SERIAL_DATA_LINE_OUT = 1'b0;
  assign SERIAL_DATA_LINE_OE = state.sda_oe;
  assign ACK_ERROR = state.ack_error;
  assign PIXEL_OUT = pix_out.value;
  assign PIXEL_OUT_VALID = pix_out_valid;
  assign PIXEL_OUT_LINE = pix_out.line_valid;
  assign PIXEL_OUT_FRAME = pix_out.frame_valid;
  assign PIXEL_OVERRUN = state.overrun;

  // Handshake returns to zero a bounded time after leaving idle.
  sequence s_busy_start;
    state.phase == IDLE && state.handshake != `HS_IDLE;
  endsequence
  a_handshake_clears: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.handshake != `HS_IDLE |-> int'(state.busy_cycles) < BUSY_LIMIT)
    else $error("handshake not cleared in time");
  a_start_prompt: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_busy_start |=> state.phase == START) else $error("transfer did not start");
  a_reset_idle: assert property (@(posedge REF_CLK)
    RESET |=> state.handshake == `HS_IDLE) else $error("handshake not zero after reset");
  a_code_valid: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.handshake != 2'h3) else $error("invalid handshake code held");
  a_busy_held: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.phase inside {START, SHIFT, RESTART, STOP} |-> state.handshake != `HS_IDLE)
    else $error("handshake cleared mid transfer");
  a_done_clears: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.phase == DONE |=> state.handshake == `HS_IDLE) else $error("handshake not cleared");
  a_data_on_low: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.phase == SHIFT && $changed(state.sda) |-> !state.scl)
    else $error("data changed while clock high");
  a_stop_order: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.phase == STOP && $rose(state.sda) |-> state.scl) else $error("stop out of order");
  a_start_order: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.phase == START && $fell(state.sda) |-> state.scl) else $error("start out of order");
  a_pixel_forward: assert property (@(posedge REF_CLK) disable iff (RESET)
    state.pix_valid && pix_ready |=> pix_out_valid) else $error("pixel not forwarded");
endmodule
`default_nettype wire

// >>> verif/camera_sensor_model.sv
/*
  Behavioural image sensor on the two-wire bus, holding 16-bit registers.
  Assumes resolved, pulled-up line levels from the bench.
*/
`default_nettype none
`include "cam_cfg_map.svh"
module camera_sensor_model
  import cam_cfg_pkg::*;
(
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitn = 0;
  int byten = 0;
  logic tx_mode = 1'b0;
  logic go_tx = 1'b0;
  logic [7:0] sh;
  logic [7:0] addr;
  logic [7:0] idx;
  logic [7:0] hi;
  logic [15:0] tx;
  logic [15:0] mem [256];
  initial pull = 1'b0;
  // Power-up window origin; the bench reads these back unchanged.
  initial begin
    mem[8'h01] = 16'h000C;
    mem[8'h02] = 16'h001E;
  end
  // Start and stop both restart the byte framing and release the line.
  task automatic clear();
    bitn = 0;
    byten = 0;
    tx_mode = 1'b0;
    go_tx = 1'b0;
    pull = 1'b0;
  endtask
  // Data falling while the clock is high is a start or repeated start.
  always @(negedge sda) if (scl) clear();
  // Data rising while the clock is high ends the transfer.
  always @(posedge sda) if (scl) clear();
  // Bits are taken on the rising clock; a whole byte is then filed by position.
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (tx_mode && sda) tx_mode = 1'b0;
    bitn = bitn + 1;
    if (bitn == 8 && !tx_mode) begin
      if (byten == 0) addr = sh;
      if (byten == 0 && sh[0]) go_tx = 1'b1;
      if (byten == 1) idx = sh;
      if (byten == 2) hi = sh;
      if (byten == 3) mem[idx] = {hi, sh};
      byten = byten + 1;
    end
  end
  // The line is only changed while the clock is low: acks and read data.
  always @(negedge scl) begin
    if (bitn == 9) begin
      bitn = 0;
      if (go_tx) begin
        tx_mode = 1'b1;
        tx = mem[idx];
        go_tx = 1'b0;
      end
    end
    if (bitn == 8) pull = !tx_mode && !nack;
    else if (tx_mode) begin
      pull = !tx[15];
      tx = {tx[14:0], 1'b0};
    end else pull = 1'b0;
  end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
/*
  Self-checking bench for the camera configuration controller.
  Assumes the design files and the sensor model are compiled first.
*/
`default_nettype none
`include "cam_cfg_map.svh"
module testbench
  import cam_cfg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] sel = 2'h0;
  logic wr = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] rd;
  logic scl_oe, scl_out, sda_out, sda_oe, ack_error, cam_pull;
  logic nack = 1'b0;
  logic pix_clk = 1'b0;
  logic [9:0] pix_data = 10'h000;
  logic line_v = 1'b0;
  logic frame_v = 1'b0;
  logic [9:0] pix_out;
  logic pix_valid, pix_line, pix_frame, overrun;
  logic pix_ready = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  // Both serial lines are pulled up; the controller may pull either low, the sensor only data.
  wire logic scl_line = !scl_oe;
  wire logic sda_line = !(sda_oe || cam_pull);
  always #25 ref_clk = ~ref_clk;
  camera_serial_config_controller u_dut (
    .REF_CLK(ref_clk), .RESET(reset), .REG_SELECT(sel), .REG_WRITE(wr),
    .REG_READ(rd_en), .REG_WRITE_DATA(wdata), .REG_READ_DATA(rdata),
    .SERIAL_CLOCK_OUT(scl_out), .SERIAL_CLOCK_OE(scl_oe), .SERIAL_DATA_LINE_IN(sda_line),
    .SERIAL_DATA_LINE_OUT(sda_out), .SERIAL_DATA_LINE_OE(sda_oe), .ACK_ERROR(ack_error),
    .PIXEL_CLOCK(pix_clk), .PIXEL_DATA(pix_data), .LINE_VALID(line_v),
    .FRAME_VALID(frame_v), .PIXEL_OUT(pix_out), .PIXEL_OUT_VALID(pix_valid),
    .PIXEL_OUT_LINE(pix_line), .PIXEL_OUT_FRAME(pix_frame),
    .PIXEL_OUT_READY(pix_ready), .PIXEL_OVERRUN(overrun)
  );
  camera_sensor_model u_cam (.scl(scl_line), .sda(sda_line), .nack(nack), .pull(cam_pull));
  // Ends the run with the counts and the verdict.
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge ref_clk);
    sel <= s;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] s, output logic [15:0] d);
    @(posedge ref_clk);
    sel <= s;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    #1 d = rdata;
  endtask
  // Polls the handshake with a bounded count until the transfer is over.
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 16'h0001;
    while (rd !== 16'h0000 && n < 6000) begin
      reg_rd(2'h0, rd);
      n++;
    end
    check_val(rd, 16'h0000);
  endtask
  task automatic test_regs();
    for (int s = 0; s < 4; s++) begin
      reg_rd(2'(s), rd);
      check_val(rd, 16'h0000);
    end
    reg_wr(2'h0, 16'h0003);
    reg_rd(2'h0, rd);
    check_val(rd, 16'h0000);
    reg_wr(2'h2, 16'hA5C3);
    reg_rd(2'h2, rd);
    check_val(rd, 16'hA5C3);
    $display("test_regs done");
  endtask
  task automatic test_writes();
    logic [7:0] idx [4] = '{8'h03, 8'h04, 8'h05, 8'h06};
    logic [15:0] val [4] = '{16'h01E0, 16'h0280, 16'h00CA, 16'h0019};
    for (int i = 0; i < 4; i++) begin
      reg_wr(2'h1, {8'h00, idx[i]});
      reg_wr(2'h2, val[i]);
      reg_wr(2'h0, 16'h0002);
      reg_wr(2'h0, 16'h0001);
      reg_rd(2'h0, rd);
      check_val(rd, 16'h0002);
      wait_idle();
      check_val(u_cam.mem[idx[i]], val[i]);
      check_val({8'h00, u_cam.addr}, 16'h00BA);
      check_val({15'h0000, ack_error}, 16'h0000);
    end
    $display("test_writes done");
  endtask
  task automatic test_nack();
    nack <= 1'b1;
    reg_wr(2'h0, 16'h0002);
    wait_idle();
    check_val({15'h0000, ack_error}, 16'h0001);
    check_val({14'h0000, scl_line, sda_line}, 16'h0003);
    check_val({14'h0000, scl_out, sda_out}, 16'h0000);
    nack <= 1'b0;
    $display("test_nack done");
  endtask
  task automatic test_read();
    logic [7:0] idx [3] = '{8'h04, 8'h01, 8'h02};
    logic [15:0] val [3] = '{16'h0280, 16'h000C, 16'h001E};
    for (int i = 0; i < 3; i++) begin
      reg_wr(2'h2, 16'h0000);
      reg_wr(2'h1, {8'h00, idx[i]});
      reg_wr(2'h0, 16'h0001);
      reg_rd(2'h0, rd);
      check_val(rd, 16'h0001);
      wait_idle();
      reg_rd(2'h2, rd);
      check_val(rd, val[i]);
      check_val({15'h0000, ack_error}, 16'h0000);
    end
    $display("test_read done");
  endtask
  // The pixel clock runs only inside the frame, out of phase with REF_CLK.
  task automatic send_pix(input logic [9:0] v);
    pix_data = v;
    #200 pix_clk = 1'b1;
    #200 pix_clk = 1'b0;
  endtask
  task automatic take_pix(input logic [9:0] v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (pix_valid !== 1'b1 && n < 100);
    check_val({6'h00, pix_out}, {6'h00, v});
    check_val({13'h0000, pix_valid, pix_line, pix_frame}, 16'h0007);
    @(posedge ref_clk);
    pix_ready <= 1'b1;
    @(posedge ref_clk);
    pix_ready <= 1'b0;
  endtask
  task automatic test_pixels();
    @(posedge ref_clk);
    #17 frame_v = 1'b1;
    line_v = 1'b1;
    send_pix(10'h3A5);
    send_pix(10'h15A);
    check_val({15'h0000, overrun}, 16'h0000);
    send_pix(10'h2C3);
    #100 check_val({15'h0000, overrun}, 16'h0001);
    take_pix(10'h3A5);
    take_pix(10'h15A);
    line_v = 1'b0;
    frame_v = 1'b0;
    $display("test_pixels done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    test_regs();
    test_writes();
    test_nack();
    test_read();
    test_pixels();
    test_done();
  end
  // Cuts a hang short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      test_done();
    end
  end
endmodule
`default_nettype wire
